/* hw/mide_core.sv */
// Decode and execute unit for a 14-bit instruction subset.
// Assumes a program memory that offers words by valid/ready and a data file
// that answers a read address combinationally and takes one write per cycle.
//
// Operation
// (RULE1) Add with carry, flags C, DC, Z
// (RULE2) Subtract with borrow, flags C, DC, Z
// (RULE3) OR accumulator into register, zero only
// (RULE4) Rotate register left through carry
// (RULE5) Destination bit picks accumulator or register
// (RULE6) Increment register, skip when result zero
// (RULE7) Bit tests skip on clear or set
// (RULE8) PC change or taken skip: two cycles
// (RULE9) Indirect access, pointer top set: extra cycle
// (RULE10) Load seven bit literal into upper latch
// (RULE11) Literal minus accumulator, flags C, DC, Z
// (RULE12) OR and XOR literal, zero flag only
// (RULE13) Return from irq pops, sets irq enable
// (RULE14) Return pops stack into PC, no flags
// (RULE15) Return with literal loads accumulator and PC
// (RULE16) All other instructions take one cycle
//
// Our own choices: the address-and-strobe port and the register addresses.
module mide_core (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [mide_pkg::WORD_W-1:0] instr,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic [mide_pkg::FADDR_W-1:0] freg_raddr,
   input wire logic [mide_pkg::DATA_W-1:0] freg_rdata,
   output logic freg_we,
   output logic [mide_pkg::FADDR_W-1:0] freg_waddr,
   output logic [mide_pkg::DATA_W-1:0] freg_wdata,
   input wire logic pointer_register0_msb,
   input wire logic pointer_register1_msb,
   input wire logic [mide_pkg::PC_W-1:0] stack_top_entry,
   output logic stack_pop,
   output logic pc_load,
   output logic [mide_pkg::PC_W-1:0] pc_value,
   output logic skip_next,
   output logic [mide_pkg::DATA_W-1:0] irq_control_reg_set,
   output logic [mide_pkg::DATA_W-1:0] acc,
   output logic carry_flag,
   output logic digit_carry_flag,
   output logic zero_flag,
   output logic [mide_pkg::PCL_W-1:0] program_counter_upper_latch
);
   import mide_pkg::*;

   // ****************************************************************
   // Decode
   // ****************************************************************
   mide_state_t state_r, state_nxt;
   logic pend_nop_r, pend_nop_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
   logic [6:0] pcl_r, pcl_nxt;
   logic we_r, we_nxt;
   logic [6:0] waddr_r, waddr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic pop_r, pop_nxt, pcld_r, pcld_nxt, skip_r, skip_nxt;
   logic [14:0] pcv_r, pcv_nxt;
   logic [7:0] irq_r, irq_nxt;
   logic [5:0] op6;
   logic [3:0] op4;
   logic [6:0] faddr;
   logic [7:0] lit, opnd, tbit;
   logic dest, accept, ind, selbit;
   logic is_addc, is_subb, is_iorf, is_rlf, is_incsz, is_btc, is_bts;
   logic is_literal_minus_acc, is_iorl, is_xorl, is_lpcl, is_ret, is_reti, is_retl;

   assign op6 = instr[OP6_MSB:OP6_LSB];
   assign op4 = instr[OP6_MSB:OP4_LSB];
   assign faddr = instr[FADDR_W-1:0];
   assign lit = instr[DATA_W-1:0];
   assign dest = instr[DEST_BIT];
   assign instr_ready = (state_r == MIDE_RUN);
   assign accept = instr_valid && instr_ready;
   assign freg_raddr = faddr;
   // A write still in flight to the same address is forwarded, since the
   // data file only sees it one cycle after the instruction that made it.
   assign opnd = (we_r && waddr_r == faddr) ? wdata_r : freg_rdata;
   assign tbit = opnd >> instr[BSEL_MSB:BSEL_LSB];
   assign selbit = tbit[0];

   assign is_addc = (op6 == OP_ADD_REG_WITH_CARRY);
   assign is_subb = (op6 == OP_SUB_REG_WITH_BORROW);
   assign is_iorf = (op6 == OP_OR_ACC_INTO_REG);
   assign is_rlf = (op6 == OP_ROTATE_LEFT_VIA_CARRY);
   assign is_incsz = (op6 == OP_INCREMENT_SKIP_ON_ZERO);
   assign is_btc = (op4 == OP_BIT_TEST_SKIP_CLEAR);
   assign is_bts = (op4 == OP_BIT_TEST_SKIP_SET);
   assign is_literal_minus_acc = (op6 == OP_LITERAL_MINUS_ACC);
   assign is_iorl = (op6 == OP_OR_LITERAL_INTO_ACC);
   assign is_xorl = (op6 == OP_XOR_LITERAL_INTO_ACC);
   assign is_lpcl = (op6 == OP_LOAD_UPPER_PC_LATCH) && instr[LOAD_UPPER_BIT];
   assign is_ret = (instr == WORD_RETURN);
   assign is_reti = (instr == WORD_RETURN_FROM_IRQ);
   assign is_retl = (op6 == OP_RETURN_WITH_LITERAL);
   // Only file-register forms can touch an indirect port.
   assign ind = (is_addc || is_subb || is_iorf || is_rlf || is_incsz || is_btc || is_bts)
      && ((faddr == ADDR_INDIRECT0 && pointer_register0_msb)
      || (faddr == ADDR_INDIRECT1 && pointer_register1_msb));

   // Returns {digit carry, carry, sum}.
   function automatic logic [9:0] mide_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      return {n[4], s};
   endfunction

   // ****************************************************************
   // Execute
   // ****************************************************************
   always_comb begin
      logic [9:0] ar;
      logic [7:0] res;
      logic wr, fl3, flz, two;
      ar = 10'h000;
      res = 8'h00;
      wr = 1'b0;
      fl3 = 1'b0;
      flz = 1'b0;
      two = 1'b0;
      state_nxt = state_r;
      pend_nop_nxt = pend_nop_r;
      acc_nxt = acc_r;
      c_nxt = c_r;
      dc_nxt = dc_r;
      z_nxt = z_r;
      pcl_nxt = pcl_r;
      we_nxt = 1'b0;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      pop_nxt = 1'b0;
      pcld_nxt = 1'b0;
      skip_nxt = 1'b0;
      pcv_nxt = pcv_r;
      irq_nxt = 8'h00;
      case (state_r)
         MIDE_RUN: begin
            if (accept) begin
               if (is_addc) begin
                  ar = mide_add(acc_r, opnd, c_r); // RULE1
                  wr = 1'b1;
                  fl3 = 1'b1;
               end else if (is_subb) begin
                  // Carry set means no borrow, so it feeds in directly.
                  ar = mide_add(opnd, ~acc_r, c_r); // RULE2
                  wr = 1'b1;
                  fl3 = 1'b1;
               end else if (is_literal_minus_acc) begin
                  ar = mide_add(lit, ~acc_r, 1'b1); // RULE11
                  fl3 = 1'b1;
                  acc_nxt = ar[7:0];
               end else if (is_iorf) begin
                  ar = {2'b00, acc_r | opnd}; // RULE3
                  wr = 1'b1;
                  flz = 1'b1;
               end else if (is_iorl) begin
                  ar = {2'b00, acc_r | lit}; // RULE12
                  flz = 1'b1;
                  acc_nxt = ar[7:0];
               end else if (is_xorl) begin
                  ar = {2'b00, acc_r ^ lit}; // RULE12
                  flz = 1'b1;
                  acc_nxt = ar[7:0];
               end else if (is_rlf) begin
                  ar = {2'b00, opnd[6:0], c_r}; // RULE4
                  c_nxt = opnd[7]; // RULE4
                  wr = 1'b1;
               end else if (is_incsz) begin
                  ar = {2'b00, opnd + 8'h01}; // RULE6
                  wr = 1'b1;
                  two = (ar[7:0] == 8'h00); // RULE6
               end else if (is_btc) begin
                  two = !selbit; // RULE7
               end else if (is_bts) begin
                  two = selbit; // RULE7
               end else if (is_lpcl) begin
                  pcl_nxt = instr[PCL_W-1:0]; // RULE10
               end else if (is_ret || is_reti || is_retl) begin
                  pop_nxt = 1'b1; // RULE14
                  pcld_nxt = 1'b1; // RULE14
                  pcv_nxt = stack_top_entry; // RULE14
                  two = 1'b1;
                  if (is_reti) begin
                     irq_nxt[GLOBAL_IRQ_ENABLE_BIT] = 1'b1; // RULE13
                  end
                  if (is_retl) begin
                     acc_nxt = lit; // RULE15
                  end
               end
               res = ar[7:0];
               if (fl3) begin
                  c_nxt = ar[8];
                  dc_nxt = ar[9];
               end
               if (fl3 || flz) begin
                  z_nxt = (res == 8'h00);
               end
               if (wr) begin
                  if (dest) begin
                     we_nxt = 1'b1; // RULE5
                     waddr_nxt = faddr;
                     wdata_nxt = res;
                  end else begin
                     acc_nxt = res; // RULE5
                  end
               end
               skip_nxt = two && !pcld_nxt;
               // The extra cycles stall the fetch port; none are taken otherwise.
               pend_nop_nxt = two && ind;
               if (ind) begin
                  state_nxt = MIDE_IND; // RULE9
               end else if (two) begin
                  state_nxt = MIDE_NOP; // RULE8
               end else begin
                  state_nxt = MIDE_RUN; // RULE16
               end
            end
         end
         MIDE_IND: begin
            pend_nop_nxt = 1'b0;
            state_nxt = pend_nop_r ? MIDE_NOP : MIDE_RUN;
         end
         MIDE_NOP: begin
            state_nxt = MIDE_RUN; // RULE8
         end
         default: begin
            state_nxt = MIDE_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= MIDE_RUN;
         pend_nop_r <= 1'b0;
         acc_r <= ACC_RST;
         c_r <= 1'b0;
         dc_r <= 1'b0;
         z_r <= 1'b0;
         pcl_r <= PCLATCH_RST;
         we_r <= 1'b0;
         waddr_r <= 7'h00;
         wdata_r <= 8'h00;
         pop_r <= 1'b0;
         pcld_r <= 1'b0;
         skip_r <= 1'b0;
         pcv_r <= 15'h0000;
         irq_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         pend_nop_r <= pend_nop_nxt;
         acc_r <= acc_nxt;
         c_r <= c_nxt;
         dc_r <= dc_nxt;
         z_r <= z_nxt;
         pcl_r <= pcl_nxt;
         we_r <= we_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         pop_r <= pop_nxt;
         pcld_r <= pcld_nxt;
         skip_r <= skip_nxt;
         pcv_r <= pcv_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign freg_we = we_r;
   assign freg_waddr = waddr_r;
   assign freg_wdata = wdata_r;
   assign stack_pop = pop_r;
   assign pc_load = pcld_r;
   assign pc_value = pcv_r;
   assign skip_next = skip_r;
   assign irq_control_reg_set = irq_r;
   assign acc = acc_r;
   assign carry_flag = c_r;
   assign digit_carry_flag = dc_r;
   assign zero_flag = z_r;
   assign program_counter_upper_latch = pcl_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_addc_sum: assert property (accept && is_addc && !dest |=> // RULE1
      {c_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(opnd)} + {8'h00, $past(c_r)})
      else $error("add with carry result wrong");
   a_subb_write: assert property (accept && is_subb && dest |=> we_r && // RULE2
      wdata_r == 8'($past(opnd) - $past(acc_r) - {7'h00, !$past(c_r)}))
      else $error("subtract with borrow result wrong");
   a_ior_zero_only: assert property (accept && is_iorf |=> // RULE3
      $stable(c_r) && $stable(dc_r) && z_r == ($past(acc_r | opnd) == 8'h00))
      else $error("or into register flags wrong");
   a_rotate_carry: assert property (accept && is_rlf && !dest |=> // RULE4
      c_r == $past(opnd[7]) && acc_r == {$past(opnd[6:0]), $past(c_r)})
      else $error("rotate through carry wrong");
   a_dest_select: assert property (accept && (is_addc || is_iorf) |=> // RULE5
      we_r == $past(dest))
      else $error("destination select wrong");
   a_inc_skip: assert property (accept && is_incsz && opnd == 8'hff && !ind |=> // RULE6
      skip_r && !instr_ready ##1 instr_ready)
      else $error("increment skip missing");
   a_bit_skip: assert property (accept && (is_btc || is_bts) && !ind |=> // RULE7
      skip_r == ($past(selbit) == $past(is_bts)))
      else $error("bit test skip wrong");
   a_two_cycle: assert property (accept && !ind && (is_ret || is_retl) |=> // RULE8
      !instr_ready ##1 instr_ready)
      else $error("two cycle timing wrong");
   a_ind_extra: assert property (accept && ind && !is_incsz && !is_btc && !is_bts |=> // RULE9
      !instr_ready ##1 instr_ready)
      else $error("indirect extra cycle wrong");
   a_upper_latch: assert property (accept && is_lpcl |=> // RULE10
      pcl_r == $past(instr[6:0]) && $stable(z_r) && $stable(c_r))
      else $error("upper latch load wrong");
   a_lit_minus: assert property (accept && is_literal_minus_acc |=> // RULE11
      acc_r == 8'($past(lit) - $past(acc_r)) && c_r == ($past(lit) >= $past(acc_r)))
      else $error("literal minus accumulator wrong");
   a_xor_lit: assert property (accept && is_xorl |=> acc_r == $past(lit ^ acc_r) // RULE12
      && $stable(c_r))
      else $error("xor literal wrong");
   a_irq_return: assert property (accept && is_reti |=> pop_r && pcld_r && // RULE13
      irq_r[GLOBAL_IRQ_ENABLE_BIT] && !instr_ready)
      else $error("return from irq wrong");
   a_sub_return: assert property (accept && is_ret |=> pop_r && // RULE14
      pc_value == $past(stack_top_entry) && $stable(z_r) && $stable(c_r))
      else $error("return wrong");
   a_lit_return: assert property (accept && is_retl |=> pcld_r && // RULE15
      acc_r == $past(lit) && pc_value == $past(stack_top_entry))
      else $error("return with literal wrong");
   a_single_cycle: assert property (accept && !ind && (is_iorl || is_lpcl || is_addc) // RULE16
      |=> instr_ready)
      else $error("single cycle instruction stalled");

   c_skip_taken: cover property (accept && is_bts ##1 skip_r);
   c_ind_and_skip: cover property (accept && ind && is_incsz ##1 state_r == MIDE_IND
      ##1 state_r == MIDE_NOP);
   c_irq_return: cover property (accept && is_reti);
   c_forward: cover property (accept && we_r && waddr_r == faddr);
endmodule // mide_core

/* hw/mide_pkg.sv */
// Constants, encodings and state codes of the instruction decode/execute unit.
// Assumes one clock; each clock is one instruction cycle, and an accepted word takes one to three of them.
package mide_pkg;
   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int WORD_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PCL_W = 7;
   localparam int PC_W = 15;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int OP6_MSB = 13;
   localparam int OP6_LSB = 8;
   localparam int OP4_LSB = 10;
   localparam int DEST_BIT = 7;
   localparam int BSEL_LSB = 7;
   localparam int BSEL_MSB = 9;
   localparam int LOAD_UPPER_BIT = 7;
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   // ****************************************************************
   // Opcode fields, bits 13..8
   // ****************************************************************
   localparam logic [5:0] OP_ADD_REG_WITH_CARRY = 6'h3d;
   localparam logic [5:0] OP_SUB_REG_WITH_BORROW = 6'h3b;
   localparam logic [5:0] OP_OR_ACC_INTO_REG = 6'h04;
   localparam logic [5:0] OP_ROTATE_LEFT_VIA_CARRY = 6'h0d;
   localparam logic [5:0] OP_INCREMENT_SKIP_ON_ZERO = 6'h0f;
   localparam logic [5:0] OP_LITERAL_MINUS_ACC = 6'h3c;
   localparam logic [5:0] OP_OR_LITERAL_INTO_ACC = 6'h38;
   localparam logic [5:0] OP_XOR_LITERAL_INTO_ACC = 6'h3a;
   localparam logic [5:0] OP_LOAD_UPPER_PC_LATCH = 6'h31;
   localparam logic [5:0] OP_RETURN_WITH_LITERAL = 6'h34;
   // Bits 13..10 of the bit tests.
   localparam logic [3:0] OP_BIT_TEST_SKIP_CLEAR = 4'h6;
   localparam logic [3:0] OP_BIT_TEST_SKIP_SET = 4'h7;
   // Whole-word encodings.
   localparam logic [13:0] WORD_RETURN = 14'h0008;
   localparam logic [13:0] WORD_RETURN_FROM_IRQ = 14'h0009;
   // File addresses of the two indirect file access ports.
   localparam logic [6:0] ADDR_INDIRECT0 = 7'h00;
   localparam logic [6:0] ADDR_INDIRECT1 = 7'h01;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [6:0] PCLATCH_RST = 7'h00;
   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      MIDE_RUN = 2'b00,
      MIDE_NOP = 2'b01,
      MIDE_IND = 2'b10
   } mide_state_t;
endpackage

/* sim/mide_file_model.sv */
// Behavioural data file and return stack that face the decode/execute unit.
// Assumes one clock: reads answer at once, a write lands on the edge that sees its strobe.
module mide_file_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [mide_pkg::FADDR_W-1:0] freg_raddr,
   output logic [mide_pkg::DATA_W-1:0] freg_rdata,
   input wire logic freg_we,
   input wire logic [mide_pkg::FADDR_W-1:0] freg_waddr,
   input wire logic [mide_pkg::DATA_W-1:0] freg_wdata,
   input wire logic stack_pop,
   output logic [mide_pkg::PC_W-1:0] stack_top_entry
);
   timeunit 1ns;
   timeprecision 100ps;
   import mide_pkg::*;
   // The bench preloads cells directly, so plain always is used instead of always_ff.
   logic [DATA_W-1:0] mem [0:127];
   logic [1:0] sp_r;
   assign freg_rdata = mem[freg_raddr];
   assign stack_top_entry = 15'h1230 + {13'h0000, sp_r};
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sp_r <= 2'h3;
      end else if (stack_pop) begin
         sp_r <= sp_r - 2'h1;
      end
      if (freg_we) begin
         mem[freg_waddr] <= freg_wdata;
      end
   end
endmodule // mide_file_model

/* sim/mide_core_tb.sv */
// Self-checking bench for the decode/execute unit.
// Assumes the file model beside it; every word is offered alone and watched for three cycles.
module mide_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mide_pkg::*;
   logic ref_clk, sys_rst, instr_valid, instr_ready, freg_we, stack_pop, pc_load, skip_next;
   logic ptr0_msb, ptr1_msb, carry_flag, digit_carry_flag, zero_flag;
   logic [WORD_W-1:0] instr;
   logic [FADDR_W-1:0] freg_raddr, freg_waddr;
   logic [DATA_W-1:0] freg_rdata, freg_wdata, irq_set, acc;
   logic [PC_W-1:0] stack_top, pc_value;
   logic [PCL_W-1:0] upper_latch;
   int fails, check_count;
   logic s_we, s_skip, s_pop, s_pcl;
   logic [6:0] s_wa;
   logic [7:0] s_wd, s_irq;
   logic [14:0] s_pcv;
   logic [2:0] s_rdy;
   int i;
   mide_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr(instr),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .freg_raddr(freg_raddr),
      .freg_rdata(freg_rdata), .freg_we(freg_we), .freg_waddr(freg_waddr),
      .freg_wdata(freg_wdata), .pointer_register0_msb(ptr0_msb),
      .pointer_register1_msb(ptr1_msb), .stack_top_entry(stack_top), .stack_pop(stack_pop),
      .pc_load(pc_load), .pc_value(pc_value), .skip_next(skip_next),
      .irq_control_reg_set(irq_set), .acc(acc), .carry_flag(carry_flag),
      .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
      .program_counter_upper_latch(upper_latch));
   mide_file_model fmod (.ref_clk(ref_clk), .sys_rst(sys_rst), .freg_raddr(freg_raddr),
      .freg_rdata(freg_rdata), .freg_we(freg_we), .freg_waddr(freg_waddr),
      .freg_wdata(freg_wdata), .stack_pop(stack_pop), .stack_top_entry(stack_top));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   // Wide enough for the longest packed comparison, so no field is cut off.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Readiness is sampled in each of the three cycles after the word is taken.
   task exec(input logic [13:0] w);
      int n;
      n = 0;
      @(posedge ref_clk);
      instr <= w;
      instr_valid <= 1'b1;
      #1;
      while (instr_ready !== 1'b1) begin
         n++;
         if (n > 8) begin
            fails++;
            give_verdict();
         end
         @(posedge ref_clk);
         #1;
      end
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      {s_we, s_wa, s_wd, s_skip} = {freg_we, freg_waddr, freg_wdata, skip_next};
      {s_pop, s_pcl, s_pcv, s_irq} = {stack_pop, pc_load, pc_value, irq_set};
      s_rdy[0] = instr_ready;
      @(posedge ref_clk);
      #1;
      s_rdy[1] = instr_ready;
      @(posedge ref_clk);
      #1;
      s_rdy[2] = instr_ready;
   endtask
   task flags(input logic [2:0] exp);
      check({29'h00000000, carry_flag, digit_carry_flag, zero_flag}, {29'h00000000, exp});
   endtask
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      {sys_rst, instr_valid, instr, ptr0_msb, ptr1_msb} = {1'b1, 1'b0, 14'h0000, 2'b00};
      {fails, check_count} = {32'd0, 32'd0};
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      check(acc, ACC_RST);
      check(upper_latch, PCLATCH_RST);
      flags(3'b000);
      fmod.mem[7'h20] = 8'h8f;
      fmod.mem[7'h21] = 8'h5a;
      fmod.mem[7'h22] = 8'h66;
      fmod.mem[7'h23] = 8'hff;
      fmod.mem[7'h24] = 8'h10;
      fmod.mem[7'h00] = 8'hff;
      fmod.mem[7'h01] = 8'h00;
      exec({OP_OR_LITERAL_INTO_ACC, 8'h81});
      check(acc, 8'h81);
      exec({OP_XOR_LITERAL_INTO_ACC, 8'h81});
      check(acc, 8'h00);
      flags(3'b001);
      exec({OP_XOR_LITERAL_INTO_ACC, 8'h81});
      flags(3'b000);
      exec({OP_ADD_REG_WITH_CARRY, 1'b0, 7'h20});
      check(acc, 8'h10);
      flags(3'b110);
      check(s_rdy, 3'b111);
      exec({OP_ADD_REG_WITH_CARRY, 1'b1, 7'h20});
      check({s_we, s_wa, s_wd}, {1'b1, 7'h20, 8'ha0});
      check(acc, 8'h10);
      flags(3'b010);
      exec({OP_SUB_REG_WITH_BORROW, 1'b0, 7'h20});
      check(acc, 8'h8f);
      flags(3'b100);
      exec({OP_LITERAL_MINUS_ACC, 8'h8f});
      check(acc, 8'h00);
      flags(3'b111);
      exec({OP_OR_ACC_INTO_REG, 1'b1, 7'h21});
      check({s_we, s_wa, s_wd}, {1'b1, 7'h21, 8'h5a});
      flags(3'b110);
      exec({OP_ROTATE_LEFT_VIA_CARRY, 1'b0, 7'h22});
      check({s_we, acc}, {1'b0, 8'hcd});
      flags(3'b010);
      exec({OP_INCREMENT_SKIP_ON_ZERO, 1'b1, 7'h23});
      check({s_we, s_wa, s_wd, s_skip}, {1'b1, 7'h23, 8'h00, 1'b1});
      check(s_rdy, 3'b110);
      exec({OP_INCREMENT_SKIP_ON_ZERO, 1'b1, 7'h23});
      check({s_wd, s_skip, s_rdy}, {8'h01, 1'b0, 3'b111});
      for (i = 0; i < 4; i++) begin
         exec({(i < 2) ? OP_BIT_TEST_SKIP_CLEAR : OP_BIT_TEST_SKIP_SET,
               (i[0] ? 3'd3 : 3'd4), 7'h24});
         check(s_skip, ((i[0] == 1'b0) == (i >= 2)));
      end
      exec({OP_LOAD_UPPER_PC_LATCH, 1'b1, 7'h55});
      check(upper_latch, 7'h55);
      check(acc, 8'hcd);
      flags(3'b010);
      exec({OP_RETURN_WITH_LITERAL, 8'h3c});
      check({acc, s_pop, s_pcl}, {8'h3c, 2'b11});
      check({s_pcv, s_rdy}, {15'h1233, 3'b110});
      exec(WORD_RETURN);
      check({s_pop, s_pcl, s_pcv, s_irq}, {2'b11, 15'h1232, 8'h00});
      flags(3'b010);
      check(s_rdy, 3'b110);
      exec(WORD_RETURN_FROM_IRQ);
      check({s_pop, s_pcl, s_pcv, s_rdy}, {2'b11, 15'h1231, 3'b110});
      check(s_irq[GLOBAL_IRQ_ENABLE_BIT], 1'b1);
      @(posedge ref_clk);
      ptr0_msb <= 1'b1;
      ptr1_msb <= 1'b1;
      exec({OP_INCREMENT_SKIP_ON_ZERO, 1'b1, ADDR_INDIRECT0});
      check({s_skip, s_rdy}, {1'b1, 3'b100});
      exec({OP_OR_ACC_INTO_REG, 1'b0, ADDR_INDIRECT1});
      check({acc, s_rdy}, {8'h3c, 3'b110});
      @(posedge ref_clk);
      ptr1_msb <= 1'b0;
      exec({OP_OR_ACC_INTO_REG, 1'b0, ADDR_INDIRECT1});
      check(s_rdy, 3'b111);
      give_verdict();
   end
endmodule // mide_core_tb
